// ===== pdms_pkg.sv
// Constants, register map and types for the PWM duty motor startup block.
package pdms_pkg;

  ////////////////////////////////////////////////////////////////////////////
  localparam int CLK_PERIOD_NS = 10;
  localparam int COMM_UNIT_NS = 10000;
  localparam int RAMP_UNIT_NS = 1000;
  localparam int SAMPLE_UNIT_NS = 1000;
  localparam int WDOG_TIMEOUT_NS = 100000000;
  localparam logic [23:0] COMM_UNIT_CYC = 24'((COMM_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam logic [23:0] RAMP_UNIT_CYC = 24'((RAMP_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int SAMPLE_DIV_CYC = (SAMPLE_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WDOG_TIMEOUT_CYC = WDOG_TIMEOUT_NS / CLK_PERIOD_NS;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_DUTY_TH = 8'h04;
  localparam logic [7:0] OFF_BEHAV = 8'h08;
  localparam logic [7:0] OFF_STARTUP = 8'h0C;
  localparam logic [7:0] OFF_CUR_LIM = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_IRQ_STAT = 8'h18;
  localparam logic [7:0] OFF_IRQ_MASK = 8'h1C;
  localparam logic [7:0] OFF_WDOG = 8'h20;

  localparam int CTRL_RUN_BIT = 0;
  localparam int CTRL_SPEED_FB_BIT = 1;
  localparam int DUTY_LO_LSB = 0;
  localparam int DUTY_HI_LSB = 8;
  localparam int LOW_SEL_LSB = 0;
  localparam int HIGH_SEL_LSB = 4;
  localparam int COMM_PER_LSB = 0;
  localparam int SS_DUR_LSB = 8;
  localparam int STAT_MISSING_BIT = 3;
  localparam int STAT_WDOG_BIT = 4;
  localparam int STAT_IN_DUTY_LSB = 8;
  localparam int STAT_MOT_DUTY_LSB = 16;
  localparam int IRQ_PWM_FAULT = 0;
  localparam int IRQ_WDOG = 1;
  localparam int IRQ_CLOSED = 2;
  localparam int IRQ_REFUSED = 3;
  localparam int IRQ_BITS = 4;

  localparam logic [7:0] RST_DUTY_LO = 8'h00;
  localparam logic [7:0] RST_DUTY_HI = 8'hFF;
  localparam logic [2:0] RST_LOW_SEL = 3'h1;
  localparam logic [2:0] RST_HIGH_SEL = 3'h2;
  localparam logic [7:0] RST_COMM_PER = 8'h20;
  localparam logic [7:0] RST_SS_DUR = 8'h10;
  localparam logic [7:0] RST_CUR_LIM = 8'hFF;

  ////////////////////////////////////////////////////////////////////////////
  localparam logic [2:0] SEL_OFF = 3'h0;
  localparam logic [2:0] SEL_SAFE = 3'h1;
  localparam logic [2:0] SEL_FULL = 3'h2;
  localparam logic [7:0] DUTY_ZERO = 8'h00;
  localparam logic [7:0] DUTY_SAFE = 8'h40;
  localparam logic [7:0] DUTY_FULL = 8'hFF;
  localparam logic [2:0] PHASE_LAST = 3'h5;

  typedef enum logic [2:0] {
    ST_STANDBY = 3'b001,
    ST_STARTUP = 3'b010,
    ST_CLOSED = 3'b100
  } pdms_state_t;

endpackage

// ===== pdms_duty_meter.sv
// Measures the duty cycle of the speed-command input and flags a missing signal.
`timescale 1ns/10ps
module pdms_duty_meter #(
  parameter int SAMPLE_DIV = pdms_pkg::SAMPLE_DIV_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_pwm,
  output logic [7:0] o_duty,
  output logic o_missing,
  output logic o_update
);
  import pdms_pkg::*;

  logic [15:0] div_reg, div_next;
  logic [7:0] smp_reg, smp_next;
  logic [7:0] high_reg, high_next;
  logic edge_reg, edge_next;
  logic prev_reg, prev_next;
  logic [7:0] duty_reg, duty_next;
  logic miss_reg, miss_next;
  logic upd_reg, upd_next;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    div_next = div_reg + 16'h0001;
    smp_next = smp_reg;
    high_next = high_reg;
    edge_next = edge_reg;
    prev_next = prev_reg;
    duty_next = duty_reg;
    miss_next = miss_reg;
    upd_next = 1'b0;
    if (div_reg == 16'(SAMPLE_DIV - 1)) begin
      div_next = 16'h0000;
      prev_next = i_pwm;
      edge_next = edge_reg | (i_pwm != prev_reg);
      high_next = high_reg + {7'h00, i_pwm};
      smp_next = smp_reg + 8'h01;
      if (smp_reg == 8'hFE) begin
        duty_next = high_reg + {7'h00, i_pwm};
        miss_next = ~(edge_reg | (i_pwm != prev_reg));
        upd_next = 1'b1;
        smp_next = 8'h00;
        high_next = 8'h00;
        edge_next = 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      div_reg <= 16'h0000;
      smp_reg <= 8'h00;
      high_reg <= 8'h00;
      edge_reg <= 1'b0;
      prev_reg <= 1'b0;
      duty_reg <= 8'h00;
      miss_reg <= 1'b1;
      upd_reg <= 1'b0;
    end else begin
      div_reg <= div_next;
      smp_reg <= smp_next;
      high_reg <= high_next;
      edge_reg <= edge_next;
      prev_reg <= prev_next;
      duty_reg <= duty_next;
      miss_reg <= miss_next;
      upd_reg <= upd_next;
    end
  end

  assign o_duty = duty_reg;
  assign o_missing = miss_reg;
  assign o_update = upd_reg;

endmodule

// ===== pdms_motor_ctrl.sv
// Duty translation, soft-start and run control of the motor drive with an APB register file.
//
// Added by the designer: the APB slave port and the placing of the registers.
`timescale 1ns/10ps
// Summary of operation
// - No input pulses raises the input fault flag; low select chooses behaviour, e.g. 25%.
// - Watchdog not serviced within its interval reports a timeout error.
// - Input duty below lower threshold applies the low-input behaviour select.
// - Input duty between thresholds maps linearly onto zero to full drive.
// - Input duty above upper threshold applies the high-input behaviour select.
// - Start commutates open-loop; closed loop only after back-EMF is valid.
// - Startup period sets open-loop commutation rate; soft-start duration sets ramp time.
// - During soft start the current limit ramps from zero to the configured limit.
// - Some settings accept writes while running; others only in standby.
module pdms_motor_ctrl #(
  parameter int WDOG_CYC = pdms_pkg::WDOG_TIMEOUT_CYC,
  parameter int SAMPLE_DIV = pdms_pkg::SAMPLE_DIV_CYC
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  input wire logic i_pwm,
  input wire logic i_bemf_valid,
  input wire logic i_bemf_zero_cross,
  output logic o_drive_en,
  output logic [7:0] o_motor_duty,
  output logic [7:0] o_current_limit,
  output logic [2:0] o_phase_step,
  output logic o_commutate,
  output logic [2:0] o_operating_state_indicator,
  output logic o_irq
);
  import pdms_pkg::*;

  function automatic logic [7:0] behaviour_duty(input logic [2:0] sel);
    case (sel)
      SEL_SAFE: behaviour_duty = DUTY_SAFE;
      SEL_FULL: behaviour_duty = DUTY_FULL;
      default: behaviour_duty = DUTY_ZERO;
    endcase
  endfunction

  function automatic logic [23:0] to_cycles(input logic [7:0] val, input logic [23:0] unit);
    to_cycles = 24'(val * unit);
  endfunction

  logic [7:0] in_duty;
  logic in_missing;
  logic in_update;
  pdms_duty_meter #(.SAMPLE_DIV(SAMPLE_DIV)) u_meter (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .i_pwm(i_pwm),
    .o_duty(in_duty),
    .o_missing(in_missing),
    .o_update(in_update)
  );

  ////////////////////////////////////////////////////////////////////////////
  logic run_reg, run_next;
  logic speed_feedback_enable_reg, speed_feedback_enable_next;
  logic [7:0] duty_lo_reg, duty_lo_next, duty_hi_reg, duty_hi_next;
  logic [2:0] low_input_behaviour_select_reg, low_input_behaviour_select_next;
  logic [2:0] high_input_behaviour_select_reg, high_input_behaviour_select_next;
  logic [7:0] startup_commutation_period_reg, startup_commutation_period_next;
  logic [7:0] soft_start_duration_reg, soft_start_duration_next;
  logic [7:0] cur_lim_reg, cur_lim_next;
  logic [IRQ_BITS-1:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
  logic [31:0] prdata_reg, prdata_next;
  logic [31:0] wdog_cnt_reg, wdog_cnt_next;
  logic wdog_flag_reg, wdog_flag_next;
  logic setup, access, wr, rd_stat, mapped, locked, refused, wdog_hit, wdog_srv;
  logic [IRQ_BITS-1:0] events;
  logic [31:0] rdata;
  pdms_state_t state_reg, state_next;

  assign setup = i_psel & ~i_penable;
  assign access = i_psel & i_penable;
  assign wr = access & i_pwrite;
  assign mapped = (i_paddr <= OFF_WDOG) && (i_paddr[1:0] == 2'b00);
  assign locked = (i_paddr == OFF_DUTY_TH) || (i_paddr == OFF_BEHAV) || (i_paddr == OFF_STARTUP);
  assign refused = wr & mapped & locked & (state_reg != ST_STANDBY);
  assign rd_stat = access & ~i_pwrite & (i_paddr == OFF_IRQ_STAT);
  assign wdog_srv = wr & (i_paddr == OFF_WDOG);
  assign wdog_hit = ~wdog_srv & (wdog_cnt_reg == 32'(WDOG_CYC - 1));
  assign o_pready = 1'b1;
  assign o_pslverr = access & (~mapped | refused);
  assign o_prdata = prdata_reg;
  assign o_irq = |(irq_stat_reg & irq_mask_reg);

  always_comb begin
    rdata = 32'h0000_0000;
    case (i_paddr)
      OFF_CTRL: rdata = {30'h0, speed_feedback_enable_reg, run_reg};
      OFF_DUTY_TH: rdata = {16'h0, duty_hi_reg, duty_lo_reg};
      OFF_BEHAV: rdata = {25'h0, high_input_behaviour_select_reg, 1'b0, low_input_behaviour_select_reg};
      OFF_STARTUP: rdata = {16'h0, soft_start_duration_reg, startup_commutation_period_reg};
      OFF_CUR_LIM: rdata = {24'h0, cur_lim_reg};
      OFF_STATUS: rdata = {8'h0, o_motor_duty, in_duty, 3'h0, wdog_flag_reg, in_missing, state_reg};
      OFF_IRQ_STAT: rdata = {28'h0, irq_stat_reg};
      OFF_IRQ_MASK: rdata = {28'h0, irq_mask_reg};
      default: rdata = 32'h0000_0000;
    endcase
  end

  always_comb begin
    run_next = run_reg;
    speed_feedback_enable_next = speed_feedback_enable_reg;
    duty_lo_next = duty_lo_reg;
    duty_hi_next = duty_hi_reg;
    low_input_behaviour_select_next = low_input_behaviour_select_reg;
    high_input_behaviour_select_next = high_input_behaviour_select_reg;
    startup_commutation_period_next = startup_commutation_period_reg;
    soft_start_duration_next = soft_start_duration_reg;
    cur_lim_next = cur_lim_reg;
    irq_mask_next = irq_mask_reg;
    prdata_next = setup ? rdata : prdata_reg;
    wdog_cnt_next = (wdog_srv | wdog_hit) ? 32'h0 : wdog_cnt_reg + 32'h1;
    wdog_flag_next = wdog_srv ? 1'b0 : (wdog_flag_reg | wdog_hit);
    events = '0;
    events[IRQ_PWM_FAULT] = in_update & in_missing;
    events[IRQ_WDOG] = wdog_hit;
    events[IRQ_CLOSED] = (state_reg == ST_STARTUP) && (state_next == ST_CLOSED);
    events[IRQ_REFUSED] = refused;
    irq_stat_next = irq_stat_reg;
    if (rd_stat) begin
      irq_stat_next = irq_stat_reg & ~prdata_reg[IRQ_BITS-1:0];
    end
    irq_stat_next = irq_stat_next | events;
    if (wr && mapped && !refused) begin
      case (i_paddr)
        OFF_CTRL: begin
          run_next = i_pwdata[CTRL_RUN_BIT];
          speed_feedback_enable_next = i_pwdata[CTRL_SPEED_FB_BIT];
        end
        OFF_DUTY_TH: begin
          duty_lo_next = i_pwdata[DUTY_LO_LSB +: 8];
          duty_hi_next = i_pwdata[DUTY_HI_LSB +: 8];
        end
        OFF_BEHAV: begin
          low_input_behaviour_select_next = i_pwdata[LOW_SEL_LSB +: 3];
          high_input_behaviour_select_next = i_pwdata[HIGH_SEL_LSB +: 3];
        end
        OFF_STARTUP: begin
          startup_commutation_period_next = i_pwdata[COMM_PER_LSB +: 8];
          soft_start_duration_next = i_pwdata[SS_DUR_LSB +: 8];
        end
        OFF_CUR_LIM: cur_lim_next = i_pwdata[7:0];
        OFF_IRQ_MASK: irq_mask_next = i_pwdata[IRQ_BITS-1:0];
        default: cur_lim_next = cur_lim_reg;
      endcase
    end
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      run_reg <= 1'b0;
      speed_feedback_enable_reg <= 1'b0;
      duty_lo_reg <= RST_DUTY_LO;
      duty_hi_reg <= RST_DUTY_HI;
      low_input_behaviour_select_reg <= RST_LOW_SEL;
      high_input_behaviour_select_reg <= RST_HIGH_SEL;
      startup_commutation_period_reg <= RST_COMM_PER;
      soft_start_duration_reg <= RST_SS_DUR;
      cur_lim_reg <= RST_CUR_LIM;
      irq_stat_reg <= '0;
      irq_mask_reg <= '0;
      prdata_reg <= 32'h0000_0000;
      wdog_cnt_reg <= 32'h0;
      wdog_flag_reg <= 1'b0;
    end else begin
      run_reg <= run_next;
      speed_feedback_enable_reg <= speed_feedback_enable_next;
      duty_lo_reg <= duty_lo_next;
      duty_hi_reg <= duty_hi_next;
      low_input_behaviour_select_reg <= low_input_behaviour_select_next;
      high_input_behaviour_select_reg <= high_input_behaviour_select_next;
      startup_commutation_period_reg <= startup_commutation_period_next;
      soft_start_duration_reg <= soft_start_duration_next;
      cur_lim_reg <= cur_lim_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      prdata_reg <= prdata_next;
      wdog_cnt_reg <= wdog_cnt_next;
      wdog_flag_reg <= wdog_flag_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [23:0] comm_cnt_reg, comm_cnt_next, ramp_cnt_reg, ramp_cnt_next;
  logic [7:0] ramp_reg, ramp_next, duty_reg, duty_next, req_duty;
  logic [2:0] phase_reg, phase_next;
  logic comm_reg, comm_next, comm_due, ramp_done, step;
  logic [15:0] span;

  assign comm_due = comm_cnt_reg + 24'h1 >= to_cycles(startup_commutation_period_reg, COMM_UNIT_CYC);
  assign ramp_done = ramp_reg >= cur_lim_reg;
  assign span = (duty_hi_reg > duty_lo_reg) ? {8'h0, duty_hi_reg - duty_lo_reg} : 16'h1;

  always_comb begin
    if (in_missing) begin
      req_duty = behaviour_duty(low_input_behaviour_select_reg);
    end else if (in_duty < duty_lo_reg) begin
      req_duty = behaviour_duty(low_input_behaviour_select_reg);
    end else if (in_duty > duty_hi_reg) begin
      req_duty = behaviour_duty(high_input_behaviour_select_reg);
    end else if (duty_hi_reg == duty_lo_reg) begin
      req_duty = DUTY_FULL;
    end else begin
      req_duty = 8'((16'(in_duty - duty_lo_reg) * 16'(DUTY_FULL)) / span);
    end
  end

  always_comb begin
    state_next = state_reg;
    comm_cnt_next = comm_cnt_reg + 24'h1;
    ramp_cnt_next = ramp_cnt_reg + 24'h1;
    ramp_next = ramp_reg;
    step = 1'b0;
    case (state_reg)
      ST_STANDBY: begin
        comm_cnt_next = 24'h0;
        ramp_cnt_next = 24'h0;
        ramp_next = 8'h00;
        if (run_reg) begin
          state_next = ST_STARTUP;
        end
      end
      ST_STARTUP: begin
        if (comm_due) begin
          comm_cnt_next = 24'h0;
          step = 1'b1;
        end
        if (ramp_done) begin
          ramp_next = cur_lim_reg;
          ramp_cnt_next = 24'h0;
        end else if (ramp_cnt_reg + 24'h1 >= to_cycles(soft_start_duration_reg, RAMP_UNIT_CYC)) begin
          ramp_cnt_next = 24'h0;
          ramp_next = ramp_reg + 8'h01;
        end
        if (!run_reg) begin
          state_next = ST_STANDBY;
        end else if (ramp_done && i_bemf_valid) begin
          state_next = ST_CLOSED;
        end
      end
      ST_CLOSED: begin
        comm_cnt_next = 24'h0;
        ramp_cnt_next = 24'h0;
        ramp_next = cur_lim_reg;
        step = i_bemf_zero_cross;
        if (!run_reg) begin
          state_next = ST_STANDBY;
        end else if (!i_bemf_valid) begin
          state_next = ST_STARTUP;
          ramp_next = 8'h00;
        end
      end
      default: state_next = ST_STANDBY;
    endcase
    phase_next = step ? ((phase_reg == PHASE_LAST) ? 3'h0 : phase_reg + 3'h1) : phase_reg;
    comm_next = step;
    duty_next = (state_reg == ST_STANDBY) ? DUTY_ZERO : req_duty;
  end

  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      state_reg <= ST_STANDBY;
      comm_cnt_reg <= 24'h0;
      ramp_cnt_reg <= 24'h0;
      ramp_reg <= 8'h00;
      duty_reg <= DUTY_ZERO;
      phase_reg <= 3'h0;
      comm_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      comm_cnt_reg <= comm_cnt_next;
      ramp_cnt_reg <= ramp_cnt_next;
      ramp_reg <= ramp_next;
      duty_reg <= duty_next;
      phase_reg <= phase_next;
      comm_reg <= comm_next;
    end
  end

  assign o_drive_en = (state_reg != ST_STANDBY);
  assign o_motor_duty = duty_reg;
  assign o_current_limit = ramp_reg;
  assign o_phase_step = phase_reg;
  assign o_commutate = comm_reg;
  assign o_operating_state_indicator = state_reg;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);

  property p_safe_duty;
    (state_reg != ST_STANDBY && in_missing && low_input_behaviour_select_reg == SEL_SAFE) |=> o_motor_duty == DUTY_SAFE;
  endproperty
  a_safe_duty: assert property (p_safe_duty) else $error("Missing input did not give safe duty.");
  property p_wdog;
    (wdog_cnt_reg == 32'(WDOG_CYC - 1) && !wdog_srv) |=> irq_stat_reg[IRQ_WDOG] && wdog_flag_reg;
  endproperty
  a_wdog: assert property (p_wdog) else $error("Watchdog timeout not reported.");
  property p_below;
    (state_reg != ST_STANDBY && !in_missing && in_duty < duty_lo_reg && low_input_behaviour_select_reg == SEL_OFF)
      |=> o_motor_duty == DUTY_ZERO;
  endproperty
  a_below: assert property (p_below) else $error("Low input behaviour not applied.");
  property p_top_of_range;
    (state_reg != ST_STANDBY && !in_missing && in_duty == duty_hi_reg && duty_hi_reg > duty_lo_reg)
      |=> o_motor_duty == DUTY_FULL;
  endproperty
  a_top_of_range: assert property (p_top_of_range) else $error("Upper threshold did not map to full drive.");
  property p_above;
    (state_reg != ST_STANDBY && !in_missing && in_duty > duty_hi_reg && high_input_behaviour_select_reg == SEL_FULL)
      |=> o_motor_duty == DUTY_FULL;
  endproperty
  a_above: assert property (p_above) else $error("High input behaviour not applied.");
  property p_closed_needs_bemf;
    (state_reg == ST_STARTUP && !i_bemf_valid) |=> state_reg != ST_CLOSED;
  endproperty
  a_closed_needs_bemf: assert property (p_closed_needs_bemf) else $error("Closed loop without back-EMF.");
  property p_open_commutation;
    (state_reg == ST_STARTUP && comm_due) |=> o_commutate ##1 !o_commutate[*2];
  endproperty
  a_open_commutation: assert property (p_open_commutation) else $error("Open-loop step missing.");
  property p_ramp_from_zero;
    ($past(state_reg) == ST_STANDBY && state_reg == ST_STARTUP) |-> o_current_limit == 8'h00;
  endproperty
  a_ramp_from_zero: assert property (p_ramp_from_zero) else $error("Soft start did not begin at zero.");
  property p_locked_write;
    refused |=> $stable(duty_lo_reg) && $stable(low_input_behaviour_select_reg) && $stable(soft_start_duration_reg);
  endproperty
  a_locked_write: assert property (p_locked_write) else $error("Standby-only setting changed while running.");
  property p_standby_idle;
    (state_reg == ST_STANDBY && $past(state_reg) == ST_STANDBY) |-> !o_drive_en && o_motor_duty == DUTY_ZERO;
  endproperty
  a_standby_idle: assert property (p_standby_idle) else $error("Outputs active in standby.");

  c_closed: cover property (state_reg == ST_STARTUP ##1 state_reg == ST_CLOSED);
  c_refused: cover property (refused);
  c_pwm_fault: cover property (events[IRQ_PWM_FAULT] ##1 o_irq);

endmodule

// ===== pdms_host_pwm.sv
// Host model that drives the speed-command PWM input.
`timescale 1ns/10ps
module pdms_host_pwm #(
  parameter int SAMPLE_DIV = 2
) (
  input wire logic i_sys_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_high,
  output logic o_pwm
);
  int cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // One period spans one measuring window, so the high sample count equals i_high.
  // A high count of zero leaves the line low, which is a missing command signal.
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_reg <= 0;
      o_pwm <= 1'b0;
    end else begin
      cnt_reg <= (cnt_reg == 255 * SAMPLE_DIV - 1) ? 0 : cnt_reg + 1;
      o_pwm <= (cnt_reg < int'(i_high) * SAMPLE_DIV);
    end
  end
endmodule

// ===== tb_top.sv
// Self-checking testbench of the motor control block.
`timescale 1ns/10ps
module tb_top;
  import pdms_pkg::*;
  typedef struct {logic [7:0] bh; logic [7:0] in; logic [7:0] ex;} pdms_row_t;
  logic i_sys_clk = 1'b0;
  logic i_rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic bemf = 1'b0;
  logic zc = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [7:0] high = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, r;
  logic pready, pslverr, pwm, drive_en, comm, irq, e;
  logic [7:0] duty, clim;
  logic [2:0] phase, state;
  int bad_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int comm_cnt = 0;
  int c0;
  pdms_row_t rows [11] = '{'{8'h21, 8'h00, 8'h40}, '{8'h21, 8'h10, 8'h40}, '{8'h20, 8'h10, 8'h00},
    '{8'h02, 8'h10, 8'hFF}, '{8'h03, 8'h10, 8'h00}, '{8'h02, 8'hF0, 8'h00}, '{8'h12, 8'hF0, 8'h40},
    '{8'h21, 8'hF0, 8'hFF}, '{8'h21, 8'h80, 8'h7F}, '{8'h21, 8'h20, 8'h00}, '{8'h21, 8'hE0, 8'hFF}};

  pdms_motor_ctrl #(.WDOG_CYC(200), .SAMPLE_DIV(2)) i_pdms_motor_ctrl (.i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_psel(psel), .i_penable(penable), .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .i_pwm(pwm), .i_bemf_valid(bemf),
    .i_bemf_zero_cross(zc), .o_drive_en(drive_en), .o_motor_duty(duty), .o_current_limit(clim),
    .o_phase_step(phase), .o_commutate(comm), .o_operating_state_indicator(state), .o_irq(irq));
  pdms_host_pwm #(.SAMPLE_DIV(2)) i_pdms_host_pwm (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_high(high),
    .o_pwm(pwm));

  ////////////////////////////////////////////////////////////////////////////
  initial forever #5 i_sys_clk = ~i_sys_clk;

  always @(posedge i_sys_clk) begin
    cyc++;
    if (comm === 1'b1) comm_cnt++;
    if (cyc == 60000) begin
      bad_count++;
      end_sim();
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] ex, logic [31:0] s);
    num_checks++;
    if (s !== ex) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", n, ex, s);
    end
  endtask

  task automatic tick(int n);
    repeat (n) @(posedge i_sys_clk);
    #1;
  endtask

  task automatic apb(logic w, logic [7:0] a, logic [31:0] d, output logic [31:0] rd, output logic er);
    @(posedge i_sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge i_sys_clk);
    penable <= 1'b1;
    do @(posedge i_sys_clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(logic [7:0] a, logic [31:0] d, logic ee);
    logic [31:0] x;
    logic er;
    apb(1'b1, a, d, x, er);
    chk("pslverr", ee, er);
  endtask

  task automatic rd(logic [7:0] a, output logic [31:0] x);
    logic er;
    apb(1'b0, a, 32'h0, x, er);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (6) @(posedge i_sys_clk);
    i_rst <= 1'b0;
    tick(1);
    chk("state", 3'b001, state);
    chk("drive_en", 0, drive_en);
    rd(OFF_DUTY_TH, r);
    chk("duty_th", 32'h0000FF00, r);
    rd(OFF_BEHAV, r);
    chk("behav", 32'h21, r);
    rd(OFF_STARTUP, r);
    chk("startup", 32'h1020, r);
    rd(OFF_CUR_LIM, r);
    chk("cur_lim", 32'hFF, r);
    $display("test reset done");
    wr(OFF_DUTY_TH, 32'hE020, 1'b0);
    foreach (rows[i]) begin
      wr(OFF_CTRL, 32'h0, 1'b0);
      wr(OFF_BEHAV, {24'h0, rows[i].bh}, 1'b0);
      wr(OFF_CTRL, 32'h1, 1'b0);
      @(posedge i_sys_clk) high <= rows[i].in;
      tick(1600);
      chk("motor_duty", rows[i].ex, duty);
    end
    $display("test duty table done");
    wr(OFF_CTRL, 32'h0, 1'b0);
    wr(OFF_STARTUP, 32'h0101, 1'b0);
    wr(OFF_CUR_LIM, 32'h10, 1'b0);
    wr(OFF_CTRL, 32'h3, 1'b0);
    tick(2);
    chk("state", 3'b010, state);
    chk("drive_en", 1, drive_en);
    chk("limit", 0, clim);
    tick(800);
    chk("limit mid", 1, clim > 0 && clim < 8'h10);
    tick(1000);
    chk("limit end", 8'h10, clim);
    c0 = comm_cnt;
    tick(5000);
    chk("steps", 1, comm_cnt - c0 inside {[4:6]});
    chk("state", 3'b010, state);
    @(posedge i_sys_clk) bemf <= 1'b1;
    tick(4);
    chk("state", 3'b100, state);
    c0 = comm_cnt;
    repeat (3) begin
      @(posedge i_sys_clk) zc <= 1'b1;
      @(posedge i_sys_clk) zc <= 1'b0;
      tick(20);
    end
    chk("closed steps", 3, comm_cnt - c0);
    chk("phase", comm_cnt % 6, phase);
    @(posedge i_sys_clk) bemf <= 1'b0;
    tick(2);
    chk("state", 3'b010, state);
    chk("limit", 0, clim);
    $display("test startup done");
    rd(OFF_IRQ_STAT, r);
    chk("closed irq", 1, r[IRQ_CLOSED]);
    chk("pwm fault irq", 1, r[IRQ_PWM_FAULT]);
    chk("wdog irq", 1, r[IRQ_WDOG]);
    wr(OFF_IRQ_MASK, 32'h8, 1'b0);
    wr(OFF_DUTY_TH, 32'h1234, 1'b1);
    tick(2);
    chk("irq", 1, irq);
    rd(OFF_DUTY_TH, r);
    chk("duty_th", 32'hE020, r);
    rd(OFF_IRQ_STAT, r);
    tick(2);
    chk("irq", 0, irq);
    wr(OFF_CUR_LIM, 32'h20, 1'b0);
    rd(OFF_CUR_LIM, r);
    chk("cur_lim", 32'h20, r);
    apb(1'b0, 8'h24, 32'h0, r, e);
    chk("unmapped", 1, e);
    chk("unmapped data", 0, r);
    $display("test access done");
    wr(OFF_WDOG, 32'h0, 1'b0);
    rd(OFF_STATUS, r);
    chk("wdog", 0, r[STAT_WDOG_BIT]);
    tick(250);
    rd(OFF_STATUS, r);
    chk("wdog", 1, r[STAT_WDOG_BIT]);
    $display("test watchdog done");
    wr(OFF_CTRL, 32'h0, 1'b0);
    tick(3);
    chk("state", 3'b001, state);
    chk("drive_en", 0, drive_en);
    chk("duty", 0, duty);
    $display("test standby done");
    end_sim();
  end
endmodule
